// file: common/srb_consts.svh
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
// ==========================================
// register offsets (byte addresses)
`define SRB_OFF_CTRL 8'h00
`define SRB_OFF_STAT 8'h04
`define SRB_OFF_BUF 8'h08
`define SRB_OFF_MIRR 8'h0C
`define SRB_OFF_DELAY 8'h10
`define SRB_OFF_IST 8'h14
`define SRB_OFF_ICLR 8'h18
`define SRB_OFF_IEN 8'h1C
// ==========================================
// control fields
`define SRB_CTRL_MASTER 0
`define SRB_CTRL_LSB 1
`define SRB_CTRL_PAR_EN 2
`define SRB_CTRL_PAR_ODD 3
`define SRB_CTRL_ENA_CHK 4
`define SRB_CTRL_LEN_LO 8
`define SRB_CTRL_LEN_HI 12
`define SRB_CTRL_START 31
`define SRB_CTRL_RST 13'h0010
// ==========================================
// receive buffer fields
`define SRB_BUF_PAR 26
`define SRB_BUF_TMO 25
`define SRB_BUF_LEN 24
`define SRB_DELAY_RST 32'h00000000
// ==========================================
// interrupt bits
`define SRB_IRQ_DONE 0
`define SRB_IRQ_TMO 1
`define SRB_IRQ_LEN 2
`define SRB_IRQ_PAR 3
// ==========================================
// timing
`define SRB_CLK_NS 20
`define SRB_HALF_NS 40
`define SRB_HALF_CYC ((`SRB_HALF_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS)
`define SRB_C2T_EXTRA 2
`define SRB_T2C_EXTRA 1
`endif

// file: common/srb_pkg.sv
package srb_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SHIFT,
        ST_HOLD
    } srb_state_type;
    typedef logic [7:0] srb_addr_type;
    typedef logic [31:0] srb_word_type;
endpackage

// file: rtl/srb_sync2.sv
module srb_sync2 (
    input wire logic ref_clk, // module clock
    input wire logic rst, // synchronous reset
    input wire logic [1:0] d_in, // asynchronous pin levels
    output logic [1:0] d_out // synchronised levels
);
    logic [1:0] meta_r;
    logic [1:0] meta_nxt;
    logic [1:0] sync_r;
    logic [1:0] sync_nxt;

    always_comb begin
        meta_nxt = d_in;
        sync_nxt = meta_r;
    end

    // reset to the idle pin levels: data low, enable released
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= 2'h1;
            sync_r <= 2'h1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign d_out = sync_r;
endmodule

// file: rtl/srb_rx_shift.sv
module srb_rx_shift (
    input wire logic ref_clk, // module clock
    input wire logic rst, // synchronous reset
    input wire logic clear, // start of a transfer
    input wire logic sample, // receive point pulse
    input wire logic bit_in, // sampled serial bit
    input wire logic lsb_first, // shift direction
    input wire logic [4:0] char_len, // bits per word, 2..16
    input wire logic parity_en, // parity bit follows data
    input wire logic parity_odd, // odd parity when set
    output logic [15:0] word, // right-justified data
    output logic parity_bad // parity mismatch seen
);
    logic [15:0] word_r;
    logic [15:0] word_nxt;
    logic [4:0] idx_r;
    logic [4:0] idx_nxt;
    logic bad_r;
    logic bad_nxt;

    always_comb begin
        word_nxt = word_r;
        idx_nxt = idx_r;
        bad_nxt = bad_r;
        if (clear) begin
            word_nxt = 16'h0000;
            idx_nxt = 5'h00;
            bad_nxt = 1'b0;
        end else if (sample) begin
            if (idx_r < char_len) begin
                // msb-first fills from the bottom, lsb-first places by index: both end right-justified
                if (lsb_first) begin
                    word_nxt[idx_r[3:0]] = bit_in;
                end else begin
                    word_nxt = {word_r[14:0], bit_in};
                end
                idx_nxt = idx_r + 5'h01;
            end else if (parity_en && idx_r == char_len) begin
                bad_nxt = ^word_r ^ bit_in ^ parity_odd;
                idx_nxt = idx_r + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            word_r <= 16'h0000;
            idx_r <= 5'h00;
            bad_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            idx_r <= idx_nxt;
            bad_r <= bad_nxt;
        end
    end

    assign word = word_r;
    assign parity_bad = bad_r;

    chk_msb_first_shift: assert property (@(posedge ref_clk) disable iff (rst)
        (!clear && sample && !lsb_first && idx_r < char_len) |=> (word_r[0] == $past(bit_in)))
        else $error("msb-first bit not shifted into bit 0");
endmodule

// file: rtl/srb_rx_buffer.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`include "srb_consts.svh"
// What this block does
// - master only: enable time-out drops chip select at once and sets time-out flag
// - time-out flag reads 1 after a time-out; cleared by reading the data field
// - bit 24 flags a data length error; cleared by reading the data field
// - parity flag reads 1 after a received parity mismatch, else 0
// - buffer bits 23-16 read zero and ignore writes
// - at transfer end, except after a time-out, the shift register is copied into buffer bits 15-0
// - received word is stored right-justified for any length and direction
// - mirror returns data in bits 15-0, zero above, and clears no flag
// - delay register holds four 8-bit read/write fields, reset to zero
// - select-to-transmit delay is field plus two cycles; zero means none
// - transmit-to-deselect hold is field plus one cycles; zero means none
module srb_rx_buffer (
    input wire logic ref_clk, // module clock, 50 MHz
    input wire logic rst, // synchronous reset, active high
    input wire srb_pkg::srb_addr_type addr, // register byte address
    input wire srb_pkg::srb_word_type wr_data, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output srb_pkg::srb_word_type rd_data, // read data, cycle after rd_stb
    output logic spi_clk, // serial clock to slave
    output logic select_n, // chip select, active low
    input wire logic serial_in, // serial data from slave
    input wire logic slave_enable_line_n, // slave ready, active low
    output logic irq // level interrupt
);
    import srb_pkg::*;

    // ==========================================
    // address decode
    function automatic logic hit(input srb_addr_type a, input srb_addr_type off);
        hit = (a == off);
    endfunction

    logic [1:0] pins_s;
    logic miso_s;
    logic ena_n_s;

    srb_sync2 u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d_in({serial_in, slave_enable_line_n}),
        .d_out(pins_s)
    );
    assign miso_s = pins_s[1];
    assign ena_n_s = pins_s[0];

    // ==========================================
    // registers
    logic [12:0] ctrl_r;
    logic [12:0] ctrl_nxt;
    logic [31:0] delay_r;
    logic [31:0] delay_nxt;
    logic [15:0] rxw_r;
    logic [15:0] rxw_nxt;
    logic tmo_r;
    logic tmo_nxt;
    logic len_r;
    logic len_nxt;
    logic par_r;
    logic par_nxt;
    logic [3:0] ist_r;
    logic [3:0] ist_nxt;
    logic [3:0] ien_r;
    logic [3:0] ien_nxt;
    srb_word_type rd_data_r;
    srb_word_type rd_data_nxt;
    logic irq_r;
    logic irq_nxt;

    logic wr_ctrl;
    logic rd_buf;
    logic rd_mirr;
    logic start;
    logic ev_done;
    logic ev_tmo;
    logic ev_len;
    logic ev_par;
    logic [3:0] ev_vec;
    logic [15:0] shift_word;
    logic parity_bad;

    logic master;
    logic ena_chk;
    logic [4:0] char_len;
    logic [4:0] total_bits;
    logic [7:0] c2t;
    logic [7:0] t2c;
    logic [7:0] c2e;

    assign wr_ctrl = wr_stb && hit(addr, `SRB_OFF_CTRL);
    assign rd_buf = rd_stb && hit(addr, `SRB_OFF_BUF);
    assign rd_mirr = rd_stb && hit(addr, `SRB_OFF_MIRR);
    assign master = ctrl_r[`SRB_CTRL_MASTER];
    assign ena_chk = ctrl_r[`SRB_CTRL_ENA_CHK];
    // out-of-range lengths fall back to a full 16-bit word
    assign char_len = (ctrl_r[`SRB_CTRL_LEN_HI:`SRB_CTRL_LEN_LO] < 5'h02 ||
                       ctrl_r[`SRB_CTRL_LEN_HI:`SRB_CTRL_LEN_LO] > 5'h10) ? 5'h10 :
                      ctrl_r[`SRB_CTRL_LEN_HI:`SRB_CTRL_LEN_LO];
    assign total_bits = char_len + {4'h0, ctrl_r[`SRB_CTRL_PAR_EN]};
    assign c2t = delay_r[31:24];
    assign t2c = delay_r[23:16];
    assign c2e = delay_r[7:0];
    assign start = wr_ctrl && wr_data[`SRB_CTRL_START];

    // ==========================================
    // transfer sequencer
    srb_state_type state_r;
    srb_state_type state_nxt;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic [3:0] half_r;
    logic [3:0] half_nxt;
    logic [4:0] bit_r;
    logic [4:0] bit_nxt;
    logic spi_clk_r;
    logic spi_clk_nxt;
    logic select_n_r;
    logic select_n_nxt;
    logic sample;
    logic setup_ok;
    logic tmo_hit;
    logic [8:0] tmo_lim;

    assign tmo_lim = (c2e == 8'h00) ? 9'h001 : {1'b0, c2e};
    assign setup_ok = (c2t == 8'h00) || (cnt_r >= ({1'b0, c2t} + 9'h001));
    assign tmo_hit = master && ena_chk && ena_n_s && (cnt_r >= tmo_lim);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        half_nxt = half_r;
        bit_nxt = bit_r;
        spi_clk_nxt = spi_clk_r;
        select_n_nxt = select_n_r;
        sample = 1'b0;
        ev_done = 1'b0;
        ev_tmo = 1'b0;
        ev_len = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start && master) begin
                    state_nxt = ST_SETUP;
                    select_n_nxt = 1'b0;
                    cnt_nxt = 9'h000;
                end
            end
            ST_SETUP: begin
                if (cnt_r != 9'h1FF) begin
                    cnt_nxt = cnt_r + 9'h001;
                end
                if (tmo_hit) begin
                    ev_tmo = 1'b1;
                    select_n_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (setup_ok && !(ena_chk && ena_n_s)) begin
                    state_nxt = ST_SHIFT;
                    half_nxt = 4'h0;
                    bit_nxt = 5'h00;
                end
            end
            ST_SHIFT: begin
                if (ena_chk && ena_n_s) begin
                    // slave released its enable before the word was complete
                    ev_len = 1'b1;
                    spi_clk_nxt = 1'b0;
                    state_nxt = ST_HOLD;
                    cnt_nxt = 9'h000;
                end else if (half_r == 4'(`SRB_HALF_CYC - 1)) begin
                    half_nxt = 4'h0;
                    spi_clk_nxt = !spi_clk_r;
                    if (!spi_clk_r) begin
                        bit_nxt = bit_r + 5'h01;
                    end else begin
                        // the pin reaches the logic two cycles late, so the bit the slave
                        // holds for this rise is taken at the end of the high phase
                        sample = 1'b1;
                        if (bit_r == total_bits) begin
                            state_nxt = ST_HOLD;
                            cnt_nxt = 9'h000;
                        end
                    end
                end else begin
                    half_nxt = half_r + 4'h1;
                end
            end
            ST_HOLD: begin
                cnt_nxt = cnt_r + 9'h001;
                if (t2c == 8'h00 || cnt_r == {1'b0, t2c}) begin
                    select_n_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                    ev_done = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                select_n_nxt = 1'b1;
                spi_clk_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= 9'h000;
            half_r <= 4'h0;
            bit_r <= 5'h00;
            spi_clk_r <= 1'b0;
            select_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            half_r <= half_nxt;
            bit_r <= bit_nxt;
            spi_clk_r <= spi_clk_nxt;
            select_n_r <= select_n_nxt;
        end
    end

    srb_rx_shift u_shift (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(state_r == ST_SETUP),
        .sample(sample),
        .bit_in(miso_s),
        .lsb_first(ctrl_r[`SRB_CTRL_LSB]),
        .char_len(char_len),
        .parity_en(ctrl_r[`SRB_CTRL_PAR_EN]),
        .parity_odd(ctrl_r[`SRB_CTRL_PAR_ODD]),
        .word(shift_word),
        .parity_bad(parity_bad)
    );

    assign ev_par = ev_done && parity_bad;
    assign ev_vec = {ev_par, ev_len, ev_tmo, ev_done};

    // ==========================================
    // register file
    always_comb begin
        ctrl_nxt = wr_ctrl ? wr_data[12:0] : ctrl_r;
        delay_nxt = (wr_stb && hit(addr, `SRB_OFF_DELAY)) ? wr_data : delay_r;
        ien_nxt = (wr_stb && hit(addr, `SRB_OFF_IEN)) ? wr_data[3:0] : ien_r;
        rxw_nxt = ev_done ? shift_word : rxw_r;
        // a flag raised in the same cycle as the clearing read survives it
        tmo_nxt = ev_tmo ? 1'b1 : (rd_buf ? 1'b0 : tmo_r);
        len_nxt = ev_len ? 1'b1 : (rd_buf ? 1'b0 : len_r);
        par_nxt = ev_par ? 1'b1 : (rd_buf ? 1'b0 : par_r);
        ist_nxt = ist_r;
        if (wr_stb && hit(addr, `SRB_OFF_ICLR)) begin
            ist_nxt = ist_r & ~wr_data[3:0];
        end
        ist_nxt = ist_nxt | ev_vec;
        irq_nxt = |(ist_nxt & ien_nxt);
        rd_data_nxt = 32'h00000000;
        if (rd_stb) begin
            case (addr)
                `SRB_OFF_CTRL: rd_data_nxt = {19'h00000, ctrl_r};
                `SRB_OFF_STAT: rd_data_nxt = {28'h0000000, ena_n_s, select_n_r, state_r};
                `SRB_OFF_BUF: rd_data_nxt = {5'h00, par_r, tmo_r, len_r, 8'h00, rxw_r};
                `SRB_OFF_MIRR: rd_data_nxt = {16'h0000, rxw_r};
                `SRB_OFF_DELAY: rd_data_nxt = delay_r;
                `SRB_OFF_IST: rd_data_nxt = {28'h0000000, ist_r};
                `SRB_OFF_IEN: rd_data_nxt = {28'h0000000, ien_r};
                default: rd_data_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= `SRB_CTRL_RST;
            delay_r <= `SRB_DELAY_RST;
            ien_r <= 4'h0;
            rxw_r <= 16'h0000;
            tmo_r <= 1'b0;
            len_r <= 1'b0;
            par_r <= 1'b0;
            ist_r <= 4'h0;
            irq_r <= 1'b0;
            rd_data_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            delay_r <= delay_nxt;
            ien_r <= ien_nxt;
            rxw_r <= rxw_nxt;
            tmo_r <= tmo_nxt;
            len_r <= len_nxt;
            par_r <= par_nxt;
            ist_r <= ist_nxt;
            irq_r <= irq_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign spi_clk = spi_clk_r;
    assign select_n = select_n_r;
    assign irq = irq_r;

    // ==========================================
    // checks
    chk_timeout_drops_cs: assert property (@(posedge ref_clk) disable iff (rst)
        ev_tmo |=> (select_n_r && tmo_r && state_r == ST_IDLE))
        else $error("time-out did not drop select and set flag");

    chk_tmo_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_buf && !ev_tmo) |=> !tmo_r)
        else $error("time-out flag survived buffer read");

    chk_len_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_buf && !ev_len) |=> (!len_r && !$past(rd_data_nxt[`SRB_BUF_LEN]) == !$past(len_r)))
        else $error("length flag not cleared or not reported");

    chk_parity_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
        (ev_done && parity_bad) |=> (par_r && ist_r[`SRB_IRQ_PAR]))
        else $error("parity mismatch not flagged");

    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
        rd_buf |=> (rd_data_r[23:16] == 8'h00 && rd_data_r[15:0] == $past(rxw_r)))
        else $error("buffer reserved bits not zero");

    chk_rx_load: assert property (@(posedge ref_clk) disable iff (rst)
        ev_done |=> (rxw_r == $past(shift_word) && select_n_r))
        else $error("received word not loaded at transfer end");

    chk_mirror_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_mirr && !ev_tmo && !ev_len && !ev_par) |=>
        (rd_data_r == {16'h0000, $past(rxw_r)} && tmo_r == $past(tmo_r) && len_r == $past(len_r)
         && par_r == $past(par_r)))
        else $error("mirror read wrong or cleared a flag");

    chk_delay_reset: assert property (@(posedge ref_clk)
        $past(rst) |-> (delay_r == 32'h00000000))
        else $error("delay register not zero after reset");

    chk_setup_time: assert property (@(posedge ref_clk) disable iff (rst)
        (state_r == ST_SETUP && state_nxt == ST_SHIFT && c2t != 8'h00) |->
        (cnt_r == {1'b0, c2t} + 9'h001 || (ena_chk && $past(ena_n_s))))
        else $error("setup delay not field plus two");

    chk_hold_time: assert property (@(posedge ref_clk) disable iff (rst)
        (state_r == ST_HOLD && ev_done && t2c != 8'h00) |-> (cnt_r == {1'b0, t2c}))
        else $error("hold delay not field plus one");

    chk_timeout_limit: assert property (@(posedge ref_clk) disable iff (rst)
        ev_tmo |-> (cnt_r >= tmo_lim && ena_n_s && master))
        else $error("time-out raised before enable wait elapsed");

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (irq_r == |(ist_r & ien_r)))
        else $error("interrupt level disagrees with status");
endmodule

// file: verification/srb_slave_model.sv
module srb_slave_model (
    input wire logic ref_clk, // module clock
    input wire logic select_n, // chip select
    input wire logic spi_clk, // serial clock
    output logic serial_in, // data to master
    output logic slave_enable_line_n, // ready, low active
    input wire logic [15:0] tx_word, // word to send
    input wire logic [4:0] char_len, // bits per word
    input wire logic lsb_first, // send lsb first
    input wire logic par_en, // append parity bit
    input wire logic par_odd, // odd parity
    input wire logic par_bad, // send wrong parity
    input wire logic no_enable, // never get ready
    input wire logic [4:0] drop_at, // unready after n rises, 0 never
    input wire logic [7:0] ena_wait // cycles before ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] bits;
    int nbits;
    int idx;
    int cnt = 0;
    int rises = 0;
    logic in_frame = 1'b0;
    logic sclk_d = 1'b0;
    initial serial_in = 1'b0;
    initial slave_enable_line_n = 1'b1;
    // ==========
    // new bit on each falling clock; a released line shows the inverse
    // of its last value so a late sample cannot pass on a stale bit
    always @(negedge select_n or posedge select_n or negedge spi_clk) begin
        if (select_n !== 1'b0) begin
            in_frame = 1'b0;
            serial_in = ~serial_in;
        end else if (!in_frame) begin
            for (int i = 0; i < 16; i++) begin
                bits[i] = lsb_first ? tx_word[i] : tx_word[4'(char_len - 1 - i)];
            end
            bits[char_len] = ^(tx_word & 16'((32'h1 << char_len) - 1)) ^ par_odd ^ par_bad;
            nbits = char_len + par_en;
            idx = 0;
            in_frame = 1'b1;
            serial_in = bits[0];
        end else begin
            idx++;
            serial_in = (idx < nbits) ? bits[idx] : ~serial_in;
        end
    end
    // ==========
    // ready after ena_wait cycles; the drop is sticky, a slave that gives up
    always @(posedge ref_clk) begin
        sclk_d <= spi_clk;
        if (select_n !== 1'b0) begin
            cnt <= 0;
            rises <= 0;
            slave_enable_line_n <= 1'b1;
        end else begin
            cnt <= cnt + 1;
            if (spi_clk && !sclk_d) begin
                rises <= rises + 1;
            end
            slave_enable_line_n <= no_enable || cnt < ena_wait || (drop_at != 0 && rises >= drop_at);
        end
    end
endmodule

// file: verification/test_srb_rx_buffer.sv
`include "srb_consts.svh"
module test_srb_rx_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    import srb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    srb_addr_type addr = 8'h00;
    srb_word_type wr_data = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    srb_word_type rd_data;
    srb_word_type d;
    logic spi_clk, select_n, serial_in, ena_n, irq;
    logic [15:0] tx_word = 16'h0;
    logic [4:0] char_len = 5'h08;
    logic lsb_first = 1'b0, par_en = 1'b0, par_odd = 1'b0, par_bad = 1'b0, no_enable = 1'b0;
    logic [4:0] drop_at = 5'h00;
    logic [7:0] ena_wait = 8'h01;
    int cyc = 0, t_fall = 0, t_rise = 0, t_sclk1 = -1, t_sclk0 = 0;
    int fail_count = 0;
    int total_checks = 0;

    always #10 ref_clk = ~ref_clk;

    srb_rx_buffer dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .spi_clk(spi_clk),
        .select_n(select_n), .serial_in(serial_in), .slave_enable_line_n(ena_n), .irq(irq)
    );
    srb_slave_model slave (
        .ref_clk(ref_clk), .select_n(select_n), .spi_clk(spi_clk), .serial_in(serial_in),
        .slave_enable_line_n(ena_n), .tx_word(tx_word), .char_len(char_len), .lsb_first(lsb_first),
        .par_en(par_en), .par_odd(par_odd), .par_bad(par_bad), .no_enable(no_enable),
        .drop_at(drop_at), .ena_wait(ena_wait)
    );
    // ==========
    // cycle stamps of the link events; the ceiling cuts a hung run short
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    always @(negedge select_n) begin
        t_fall = cyc;
        t_sclk1 = -1;
    end
    always @(posedge spi_clk) if (t_sclk1 < 0) t_sclk1 = cyc;
    always @(negedge spi_clk) t_sclk0 = cyc;
    always @(posedge select_n) t_rise = cyc;
    // ==========
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input srb_word_type got, input srb_word_type exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input srb_addr_type a, input srb_word_type v);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input srb_addr_type a, output srb_word_type v);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        v = rd_data;
    endtask
    task automatic rdc(input srb_addr_type a, input srb_word_type e);
        rd(a, d);
        chk(d, e);
    endtask
    task automatic irqc(input logic e);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    function automatic srb_word_type ctl(input logic [4:0] len, input logic lsb, input logic pe, input logic po);
        return 32'h8000_0011 | {19'h0, len, 8'h00} | {28'h0, po, pe, lsb, 1'b0};
    endfunction
    task automatic xfer(input srb_word_type c);
        int n;
        int c0;
        c0 = cyc;
        n = 0;
        // start is judged against the stored mode, so the settings land first
        wr(`SRB_OFF_CTRL, c & 32'h7FFF_FFFF);
        wr(`SRB_OFF_CTRL, c);
        while (n < 2000 && t_rise <= c0) begin
            @(posedge ref_clk);
            n++;
        end
        chk_rng(n, 1, 1999);
    endtask
    // ==========
    task automatic t_regs();
        rdc(`SRB_OFF_DELAY, 32'h0);
        rdc(`SRB_OFF_BUF, 32'h0);
        rdc(`SRB_OFF_MIRR, 32'h0);
        wr(`SRB_OFF_DELAY, 32'hA53C_5AC3);
        rdc(`SRB_OFF_DELAY, 32'hA53C_5AC3);
        wr(`SRB_OFF_BUF, 32'h07FF_FFFF);
        rdc(`SRB_OFF_BUF, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0);
        $display("test registers done");
    endtask
    task automatic t_data();
        logic [15:0] w [4] = '{16'h12A5, 16'hC3E1, 16'hFFFE, 16'h0A6D};
        logic [4:0] ln [4] = '{5'h08, 5'h10, 5'h02, 5'h05};
        int c2t [4] = '{6, 0, 1, 255};
        int t2c [4] = '{3, 0, 255, 1};
        srb_word_type m;
        for (int i = 0; i < 4; i++) begin
            tx_word <= w[i];
            char_len <= ln[i];
            lsb_first <= i[0];
            par_en <= (i == 3);
            par_odd <= (i == 3);
            wr(`SRB_OFF_DELAY, {8'(c2t[i]), 8'(t2c[i]), 8'h00, 8'hFF});
            xfer(ctl(ln[i], i[0], i == 3, i == 3));
            m = (32'h1 << ln[i]) - 1;
            rdc(`SRB_OFF_MIRR, w[i] & m);
            rdc(`SRB_OFF_BUF, w[i] & m);
            chk_rng(t_sclk1 - t_fall, (c2t[i] != 0) ? c2t[i] + 2 : 0, c2t[i] + 10);
            chk_rng(t_rise - t_sclk0, (t2c[i] != 0) ? t2c[i] + 1 : 0, t2c[i] + 4);
        end
        $display("test data done");
    endtask
    task automatic t_parity();
        wr(`SRB_OFF_ICLR, 32'h0000_000F);
        wr(`SRB_OFF_IEN, 32'h0000_0008);
        wr(`SRB_OFF_DELAY, 32'h0202_00FF);
        tx_word <= 16'h005A;
        char_len <= 5'h08;
        lsb_first <= 1'b0;
        par_en <= 1'b1;
        par_odd <= 1'b0;
        par_bad <= 1'b1;
        xfer(ctl(5'h08, 1'b0, 1'b1, 1'b0));
        rdc(`SRB_OFF_MIRR, 32'h0000_005A);
        irqc(1'b1);
        rdc(`SRB_OFF_BUF, 32'h0400_005A);
        rdc(`SRB_OFF_BUF, 32'h0000_005A);
        par_bad <= 1'b0;
        $display("test parity done");
    endtask
    task automatic t_timeout();
        wr(`SRB_OFF_ICLR, 32'h0000_000F);
        wr(`SRB_OFF_IEN, 32'h0000_0002);
        wr(`SRB_OFF_DELAY, 32'h0000_0004);
        no_enable <= 1'b1;
        xfer(ctl(5'h08, 1'b0, 1'b0, 1'b0));
        chk_rng(t_rise - t_fall, 4, 8);
        chk_rng(t_sclk1, -1, -1);
        rdc(`SRB_OFF_IST, 32'h0000_0002);
        irqc(1'b1);
        wr(`SRB_OFF_IEN, 32'h0);
        irqc(1'b0);
        wr(`SRB_OFF_IEN, 32'h0000_0002);
        irqc(1'b1);
        wr(`SRB_OFF_ICLR, 32'h0000_0002);
        irqc(1'b0);
        rdc(`SRB_OFF_IST, 32'h0);
        // the aborted transfer must leave the earlier word in place
        rdc(`SRB_OFF_BUF, 32'h0200_005A);
        rdc(`SRB_OFF_BUF, 32'h0000_005A);
        // with the enable check off a silent slave still completes a word
        xfer(ctl(5'h08, 1'b0, 1'b0, 1'b0) & 32'hFFFF_FFEF);
        rdc(`SRB_OFF_BUF, 32'h0000_005A);
        no_enable <= 1'b0;
        $display("test time-out done");
    endtask
    task automatic t_length();
        wr(`SRB_OFF_ICLR, 32'h0000_000F);
        wr(`SRB_OFF_IEN, 32'h0000_0004);
        wr(`SRB_OFF_DELAY, 32'h0202_00FF);
        drop_at <= 5'h03;
        xfer(ctl(5'h08, 1'b0, 1'b0, 1'b0));
        irqc(1'b1);
        rd(`SRB_OFF_BUF, d);
        chk(d & 32'hFFFF_0000, 32'h0100_0000);
        rd(`SRB_OFF_BUF, d);
        chk(d & 32'hFFFF_0000, 32'h0);
        drop_at <= 5'h00;
        $display("test length error done");
    endtask
    task automatic t_slave();
        int tf;
        tf = t_fall;
        wr(`SRB_OFF_CTRL, 32'h0000_0810);
        wr(`SRB_OFF_CTRL, 32'h8000_0810);
        repeat (20) @(posedge ref_clk);
        chk_rng(t_fall, tf, tf);
        rdc(`SRB_OFF_STAT, 32'h0000_000C);
        $display("test slave mode done");
    endtask
    // ==========
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_data();
        t_parity();
        t_timeout();
        t_length();
        t_slave();
        end_of_test();
    end
endmodule
